// ===== hdl/mpw_top.sv
// Match based pulse width unit: counter, seven matches, six outputs.
// Assumes control ports are held steady by software-side logic on clock_in.
`timescale 1ns/1ns
module mpw_top import mpw_pkg::*; (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire mpw_cfg_s cfg_in,
   input wire logic [MPW_W-1:0] prescale_limit_in,
   input wire logic [MPW_NCAP-1:0] capture_in,
   input wire logic counter_clear_in,
   input wire logic [MPW_W-1:0] match_wdata_in,
   input wire logic [MPW_NMATCH-1:0] match_we_in,
   input wire logic [MPW_NMATCH-1:0] match_release_in,
   input wire mpw_mctl_s [MPW_NMATCH-1:0] match_ctl_in,
   input wire logic [MPW_NOUT-1:0] double_edge_in,
   input wire logic [MPW_NOUT-1:0] out_en_in,
   input wire logic [MPW_NMATCH-1:0] event_clear_in,
   output logic [MPW_NOUT-1:0] pwm_out,
   output logic [MPW_W-1:0] count_out,
   output logic [MPW_NMATCH-1:0] event_out,
   output logic running_out,
   output logic [MPW_NMATCH-1:0] release_pending_out
);
   logic [MPW_W-1:0] count_q;
   logic [MPW_W-1:0] shadow_q [MPW_NMATCH];
   logic [MPW_W-1:0] active_q [MPW_NMATCH];
   logic [MPW_NMATCH-1:0] pend_q;
   logic [MPW_NMATCH-1:0] event_q;
   logic [MPW_NOUT-1:0] pwm_q;
   logic stopped_q;
   logic [MPW_NCAP-1:0] cap_d1_q;
   logic cap_tick;
   logic base_tick;
   logic advance;
   logic [MPW_NMATCH-1:0] hit;
   logic any_stop;
   logic any_reset;
   logic cycle_wrap;
   logic run;

   function automatic logic edge_hit(input logic now, input logic prev, input mpw_edge_e sel);
      unique case (sel)
         MPW_EDGE_RISE: edge_hit = now && !prev;
         MPW_EDGE_FALL: edge_hit = !now && prev;
         default: edge_hit = now != prev;
      endcase
   endfunction

   assign run = cfg_in.count_en && !stopped_q;

   // Capture inputs are synchronous; one register gives the previous level for edge finding
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) cap_d1_q <= '0;
      else cap_d1_q <= capture_in;
   end

   assign cap_tick = edge_hit(capture_in[cfg_in.cap_sel], cap_d1_q[cfg_in.cap_sel],
                              cfg_in.cap_edge);
   assign base_tick = run && (cfg_in.counter_mode ? cap_tick : 1'b1);

   mpw_prescale u_prescale (
      .clock_in(clock_in),
      .resetn_in(resetn_in),
      .clear_in(counter_clear_in || !cfg_in.count_en),
      .tick_in(base_tick),
      .limit_in(prescale_limit_in),
      .advance_out(advance),
      .count_out()
   );

   // Matches are judged on the count value while an advance is due
   always_comb begin
      hit = '0;
      for (int i = 0; i < MPW_NMATCH; i++) begin
         hit[i] = advance && (count_q == active_q[i]);
      end
   end

   always_comb begin
      any_stop = 1'b0;
      any_reset = 1'b0;
      for (int i = 0; i < MPW_NMATCH; i++) begin
         any_stop = any_stop || (hit[i] && match_ctl_in[i].stop);
         any_reset = any_reset || (hit[i] && match_ctl_in[i].reset);
      end
      // In pulse mode the period match always ends the cycle
      if (cfg_in.pwm_en && hit[0]) any_reset = 1'b1;
   end

   assign cycle_wrap = advance && any_reset;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count_q <= MPW_ZERO;
      end else if (counter_clear_in || !cfg_in.count_en) begin
         count_q <= MPW_ZERO;
      end else if (cycle_wrap) begin
         count_q <= MPW_ZERO;
      end else if (advance) begin
         count_q <= count_q + MPW_ONE;
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) stopped_q <= 1'b0;
      else if (!cfg_in.count_en || counter_clear_in) stopped_q <= 1'b0;
      else if (any_stop) stopped_q <= 1'b1;
   end

   // Shadow writes only become active when released and the cycle wraps,
   // so a half-updated pair never yields a runt pulse. Outside pulse mode
   // the released value applies on the clock edge after the release, as in a plain timer.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pend_q <= '0;
         for (int i = 0; i < MPW_NMATCH; i++) begin
            shadow_q[i] <= MPW_ZERO;
            active_q[i] <= MPW_ZERO;
         end
      end else begin
         for (int i = 0; i < MPW_NMATCH; i++) begin
            if (match_we_in[i]) shadow_q[i] <= match_wdata_in;
            if (pend_q[i] && (cycle_wrap || !cfg_in.pwm_en)) begin
               active_q[i] <= shadow_q[i];
               pend_q[i] <= match_release_in[i];
            end else if (match_release_in[i]) begin
               pend_q[i] <= 1'b1;
            end
         end
      end
   end

   // Hardware set wins over a clear in the same cycle
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) event_q <= '0;
      else begin
         for (int i = 0; i < MPW_NMATCH; i++) begin
            if (hit[i] && match_ctl_in[i].flag_en) event_q[i] <= 1'b1;
            else if (event_clear_in[i]) event_q[i] <= 1'b0;
         end
      end
   end

   // Output n: single-edge falls at match n+1; double-edge sets at match n, clears at n+1.
   // Double-edge is meaningful on outputs 1..5; output 0 has no spare rise match.
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pwm_q <= '0;
      end else if (!cfg_in.pwm_en || !cfg_in.count_en) begin
         pwm_q <= '0;
      end else begin
         for (int n = 0; n < MPW_NOUT; n++) begin
            if (!out_en_in[n]) begin
               pwm_q[n] <= 1'b0;
            end else if (double_edge_in[n] && n > 0) begin
               // Edges may land anywhere; order of the two matches picks polarity.
               // The level carries across the wrap so a negative pulse can span it.
               if (hit[n + 1]) pwm_q[n] <= 1'b0;
               else if (hit[n]) pwm_q[n] <= 1'b1;
            end else begin
               // A fall match equal to the period wins, giving a constant low
               if (hit[n + 1]) pwm_q[n] <= 1'b0;
               else if (hit[0]) pwm_q[n] <= 1'b1;
            end
         end
      end
   end

   assign pwm_out = pwm_q;
   assign count_out = count_q;
   assign event_out = event_q;
   assign running_out = run;
   assign release_pending_out = pend_q;

   property p_period_reset;
      @(posedge clock_in) disable iff (!resetn_in)
         (cfg_in.pwm_en && hit[0] && !counter_clear_in && cfg_in.count_en) |=> count_q == MPW_ZERO;
   endproperty
   a_period_reset: assert property (p_period_reset) else $error("period match did not reset");

   property p_single_rise;
      @(posedge clock_in) disable iff (!resetn_in)
         (cfg_in.pwm_en && cfg_in.count_en && out_en_in[1] && !double_edge_in[1]
          && hit[0] && !hit[2]) |=> pwm_q[1];
   endproperty
   a_single_rise: assert property (p_single_rise) else $error("single edge did not rise");

   property p_single_fall;
      @(posedge clock_in) disable iff (!resetn_in)
         (cfg_in.pwm_en && cfg_in.count_en && hit[2]) |=> !pwm_q[1];
   endproperty
   a_single_fall: assert property (p_single_fall) else $error("output did not fall");

   property p_double_rise;
      @(posedge clock_in) disable iff (!resetn_in)
         (cfg_in.pwm_en && cfg_in.count_en && out_en_in[2] && double_edge_in[2]
          && hit[2] && !hit[3]) |=> pwm_q[2];
   endproperty
   a_double_rise: assert property (p_double_rise) else $error("double edge did not rise");

   property p_idle_low;
      @(posedge clock_in) disable iff (!resetn_in)
         !cfg_in.pwm_en |=> pwm_q == '0;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("output active while disabled");

   property p_stop;
      @(posedge clock_in) disable iff (!resetn_in)
         (any_stop && cfg_in.count_en && !counter_clear_in) |=> !run ##1 $stable(count_q);
   endproperty
   a_stop: assert property (p_stop) else $error("stop match ignored");

   property p_no_early_apply;
      @(posedge clock_in) disable iff (!resetn_in)
         (cfg_in.pwm_en && !cycle_wrap) |=> $stable(active_q[1]);
   endproperty
   a_no_early_apply: assert property (p_no_early_apply) else $error("match applied mid-cycle");

   property p_timer_count;
      @(posedge clock_in) disable iff (!resetn_in)
         (advance && !any_reset && !counter_clear_in && cfg_in.count_en)
         |=> count_q == $past(count_q) + MPW_ONE;
   endproperty
   a_timer_count: assert property (p_timer_count) else $error("counter did not advance");

   property p_event;
      @(posedge clock_in) disable iff (!resetn_in)
         (hit[1] && match_ctl_in[1].flag_en) |=> event_q[1];
   endproperty
   a_event: assert property (p_event) else $error("match event lost");

   c_wrap: cover property (@(posedge clock_in) disable iff (!resetn_in) cycle_wrap);
   c_neg_pulse: cover property (@(posedge clock_in) disable iff (!resetn_in)
      double_edge_in[2] && hit[3] ##[1:50] hit[2]);
   c_release: cover property (@(posedge clock_in) disable iff (!resetn_in)
      pend_q[1] && cycle_wrap);
   c_counter_mode: cover property (@(posedge clock_in) disable iff (!resetn_in)
      cfg_in.counter_mode && advance);
endmodule // mpw_top

// ===== hdl/mpw_pkg.sv
// Constants and carrier types for the match based pulse width unit.
// Assumes one 10 MHz clock and plain control ports, no register bus.
// Functional notes
// - Counter advances on prescaled clock ticks or on selected capture input edges.
// - Seven match registers give six single-edge or three double-edge outputs, or mixes.
// - Cycle period match resets the count, setting the shared repetition period.
// - Single-edge output rises at cycle start; its own match sets falling edge.
// - Single-edge output goes high each cycle unless programmed constant low.
// - Double-edge output uses period match plus rising and falling match registers.
// - Each extra double-edge output needs just two further match registers.
// - Double-edge edges may sit at any count position within the cycle.
// - Rise before fall gives positive pulse; fall before rise gives negative pulse.
// - Period and width are any whole number of counter counts.
// - Each match may flag an event and keep counting, stop or reset the counter.
// - Software releases new match values; in pulse mode they apply only at cycle boundary.
// - With pulse mode off the unit is a plain 32-bit prescaled timer/counter.
package mpw_pkg;
   localparam int MPW_W = 32;
   localparam int MPW_NMATCH = 7;
   localparam int MPW_NOUT = 6;
   localparam int MPW_NCAP = 2;
   localparam logic [31:0] MPW_ZERO = 32'h0000_0000;
   localparam logic [31:0] MPW_ONE = 32'h0000_0001;

   typedef enum logic [1:0] {
      MPW_ACT_CONTINUE,
      MPW_ACT_STOP,
      MPW_ACT_RESET,
      MPW_ACT_STOPRESET
   } mpw_act_e;

   typedef enum logic [1:0] {
      MPW_EDGE_RISE,
      MPW_EDGE_FALL,
      MPW_EDGE_BOTH
   } mpw_edge_e;

   // Per-match control: event enable and counter action
   typedef struct packed {
      logic flag_en;
      logic stop;
      logic reset;
   } mpw_mctl_s;

   typedef struct packed {
      logic count_en;
      logic pwm_en;
      logic counter_mode;
      logic cap_sel;
      mpw_edge_e cap_edge;
   } mpw_cfg_s;
endpackage

// ===== hdl/mpw_prescale.sv
// Prescaler: divides input ticks down to counter advance pulses.
// Assumes ticks are one-cycle enables in the clock_in domain.
`timescale 1ns/1ns
module mpw_prescale import mpw_pkg::*; (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic clear_in,
   input wire logic tick_in,
   input wire logic [MPW_W-1:0] limit_in,
   output logic advance_out,
   output logic [MPW_W-1:0] count_out
);
   logic [MPW_W-1:0] count_q;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count_q <= MPW_ZERO;
      end else if (clear_in) begin
         count_q <= MPW_ZERO;
      end else if (tick_in) begin
         if (count_q >= limit_in) count_q <= MPW_ZERO;
         else count_q <= count_q + MPW_ONE;
      end
   end

   assign advance_out = tick_in && !clear_in && (count_q >= limit_in);
   assign count_out = count_q;

   property p_wrap;
      @(posedge clock_in) disable iff (!resetn_in)
         advance_out |=> count_q == MPW_ZERO;
   endproperty
   a_wrap: assert property (p_wrap) else $error("prescaler did not restart");

   // Without a tick the divider must hold, or the counter rate drifts
   property p_hold;
      @(posedge clock_in) disable iff (!resetn_in)
         (!tick_in && !clear_in) |=> $stable(count_q);
   endproperty
   a_hold: assert property (p_hold) else $error("prescaler moved without a tick");
endmodule // mpw_prescale

// ===== bench/mpw_load.sv
// Load model: counts rising edges on pulse output 1 as the driven load sees them.
// Assumes the outputs are registered on clock_in.
`timescale 1ns/1ns
module mpw_load (
   input wire logic clock_in,
   input wire logic [5:0] drive_in,
   output logic [15:0] rises_out
);
   logic last_q = 1'b0;
   logic [15:0] rises_q = 16'h0000;
   always @(posedge clock_in) begin
      last_q <= drive_in[1];
      if (drive_in[1] === 1'b1 && last_q === 1'b0) rises_q <= rises_q + 16'h0001;
   end
   assign rises_out = rises_q;
endmodule // mpw_load

// ===== bench/match_based_pwm_unit_tb.sv
// Testbench: cycle-exact reference of counter, prescaler and outputs 1 and 2.
// Assumes the 10 MHz clock and inputs driven 1 ns after each rising edge.
`timescale 1ns/1ns
module match_based_pwm_unit_tb import mpw_pkg::*; ;
   typedef struct {logic [31:0] c; logic [5:0] p; logic [6:0] r;} mpw_note_s;
   logic clock_in = 1'b0, resetn_in = 1'b0, clr = 1'b0, run, want, pm;
   mpw_cfg_s cfg = '0;
   mpw_mctl_s [6:0] ctl = '0;
   logic [31:0] limit = 32'h0, wdata = 32'h0, cnt, mc, mpc, ml, W, F1, F3, nf, S, c1, mrise;
   logic [1:0] cap = 2'h0;
   logic [6:0] we = 7'h00, rel = 7'h00, eclr = 7'h00, ev, pend, mr, prel;
   logic [5:0] dbl = 6'h00, oen = 6'h00, pwm, mp;
   logic [15:0] rises, r0;
   int failures = 0, n_compared = 0;
   mpw_note_s notes[$];
   mpw_note_s nt;

   mpw_top mpw_top_inst (.clock_in(clock_in), .resetn_in(resetn_in), .cfg_in(cfg),
      .prescale_limit_in(limit), .capture_in(cap), .counter_clear_in(clr),
      .match_wdata_in(wdata), .match_we_in(we), .match_release_in(rel), .match_ctl_in(ctl),
      .double_edge_in(dbl), .out_en_in(oen), .event_clear_in(eclr), .pwm_out(pwm),
      .count_out(cnt), .event_out(ev), .running_out(run), .release_pending_out(pend));
   mpw_load mpw_load_inst (.clock_in(clock_in), .drive_in(pwm), .rises_out(rises));

   initial begin
      forever #50 clock_in = ~clock_in;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Watcher: each note belongs to the falling edge after the driver queued it
   always @(negedge clock_in) begin
      if (notes.size() > 0) begin
         nt = notes.pop_front();
         check("count", cnt, nt.c);
         check("pwm", {26'h0, pwm}, {26'h0, nt.p});
         check("pending", {25'h0, pend}, {25'h0, nt.r});
      end
   end

   // One clock: model the edge just taken, queue the note, then drive the next inputs
   task automatic step(input logic [6:0] w);
      logic old;
      @(posedge clock_in);
      old = mp[1];
      if (mpc == ml) begin
         mpc = 32'h0;
         if (pm) begin
            // Fall wins when both edges land on the same count
            if (mc == F1) mp[1] = 1'b0;
            else if (mc == W) mp[1] = 1'b1;
            if (mc == F3) mp[2] = 1'b0;
            else if (mc == F1) mp[2] = 1'b1;
         end
         if (mc == (pm ? W : S)) begin
            mc = 32'h0;
            if (mr[2]) F1 = nf;
            mr[2] = 1'b0;
         end else mc = mc + 32'h1;
      end else mpc = mpc + 32'h1;
      if (prel[2] && pm) mr[2] = 1'b1;
      if (mp[1] && !old) mrise = mrise + 32'h1;
      notes.push_back('{mc, mp, mr});
      #1;
      we = w;
      wdata = nf;
      // Release only off the wrap so the load point is unambiguous
      rel = (want && mc == 32'h0 && mpc == 32'h0) ? 7'h04 : 7'h00;
      if (rel[2]) want = 1'b0;
      prel = rel;
   endtask

   task automatic wr(input int i, input logic [31:0] v);
      @(posedge clock_in);
      #1;
      clr = 1'b0;
      we[i] = 1'b1;
      wdata = v;
      @(posedge clock_in);
      #1;
      we = 7'h00;
      rel[i] = 1'b1;
      @(posedge clock_in);
      #1;
      rel = 7'h00;
      // One more edge lets the released value load while pulse mode is still off
      @(posedge clock_in);
      #1;
   endtask

   initial begin
      #2_000_000;
      failures++;
      finish_test();
   end

   initial begin
      void'($urandom(98190));
      for (int k = 0; k < 2; k++) begin
         #1 resetn_in = 1'b0;
         cfg = '0;
         repeat (2) @(posedge clock_in);
         #1 resetn_in = 1'b1;
         W = $urandom_range(9, 4);
         F1 = $urandom_range(W - 2, 1);
         F3 = k ? $urandom_range(F1 - 1, 0) : $urandom_range(W - 1, F1 + 1);
         nf = $urandom_range(W - 1, 1);
         ml = $urandom_range(2, 0);
         limit = ml;
         dbl = 6'h04;
         oen = 6'h06;
         ctl[2] = 3'b100;
         wr(0, W);
         wr(2, F1);
         wr(3, F3);
         check("idle", cnt | {26'h0, pwm} | {31'h0, run}, 32'h0);
         {mc, mpc, mrise, mp, mr, prel, want, pm} = '0;
         pm = 1'b1;
         r0 = rises;
         cfg.count_en = 1'b1;
         cfg.pwm_en = 1'b1;
         for (int i = 0; i < 36 * W; i++) begin
            if (i == 12 * W + 1) want = 1'b1;
            step((i == 12 * W) ? 7'h04 : 7'h00);
         end
         @(posedge clock_in);
         #1;
         check("rises", {16'h0, rises - r0}, mrise);
         check("event2", {31'h0, ev[2]}, 32'h1);
      end
      // Plain timer: match 1 resets, then stops the count
      S = $urandom_range(W - 1, 2);
      cfg.pwm_en = 1'b0;
      cfg.count_en = 1'b0;
      oen = 6'h00;
      ml = 32'h0;
      limit = 32'h0;
      clr = 1'b1;
      ctl[1] = 3'b101;
      wr(1, S);
      {mc, mpc, mp, mr, prel, pm} = '0;
      cfg.count_en = 1'b1;
      repeat (6 * S) step(7'h00);
      ctl[1] = 3'b110;
      repeat (3 * S) @(posedge clock_in);
      #1;
      c1 = cnt;
      repeat (3) @(posedge clock_in);
      #1;
      check("stopped", cnt, c1);
      check("running", {31'h0, run}, 32'h0);
      check("event1", {31'h0, ev[1]}, 32'h1);
      ctl[1] = 3'b000;
      eclr = 7'h02;
      @(posedge clock_in);
      #1;
      eclr = 7'h00;
      @(posedge clock_in);
      #1;
      check("evclear", {31'h0, ev[1]}, 32'h0);
      // Counter mode: capture input 1 clocks the count, input 0 is random noise
      for (int e = 0; e < 3; e++) begin
         clr = 1'b1;
         cfg.count_en = 1'b0;
         @(posedge clock_in);
         #1;
         clr = 1'b0;
         cfg.counter_mode = 1'b1;
         cfg.cap_sel = 1'b1;
         cfg.cap_edge = mpw_edge_e'(e);
         cfg.count_en = 1'b1;
         for (int j = 0; j < 10; j++) begin
            repeat (2) @(posedge clock_in);
            #1;
            cap = {~cap[1], 1'($urandom)};
         end
         repeat (4) @(posedge clock_in);
         #1;
         check("edges", cnt, (e == 2) ? 32'ha : 32'h5);
      end
      finish_test();
   end
endmodule // match_based_pwm_unit_tb
